/* logic/himg_pkg.sv */
// package of the interrupt mask gate: register map, field layout, reset values
// assumes an ahb-lite slave with 32-bit data, single word transfers only
package himg_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] HIMG_OFF_ENABLE_SET = 8'h88;
    localparam logic [7:0] HIMG_OFF_ENABLE_CLEAR = 8'h8c;
    localparam logic [7:0] HIMG_OFF_EVENT_VIEW = 8'h90;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int HIMG_BIT_GLOBAL_IRQ_GATE = 31;
    localparam int HIMG_BIT_MAKER_EXTRA_SOURCE = 30;
    localparam int HIMG_BIT_LINK_REG_VALUE_ARRIVED = 26;
    localparam int HIMG_BIT_OVERLONG_CYCLE = 25;
    localparam int HIMG_BIT_FATAL_FAULT = 24;
    localparam int HIMG_BIT_CYCLE_TIMER_MISMATCH = 23;
    localparam int HIMG_BIT_MISSED_CYCLE_START = 22;
    localparam int HIMG_BIT_TIMER_SECONDS_ROLLOVER = 21;
    localparam int HIMG_BIT_NEW_CYCLE_BEGAN = 20;
    localparam int HIMG_BIT_LINK_STATUS_XFER = 19;
    localparam int HIMG_BIT_SERIAL_BUS_REINIT = 17;
    localparam int HIMG_BIT_IDENTITY_STREAM_DONE = 16;
    localparam int HIMG_BIT_LOCK_REPLY_FAILED = 9;
    localparam int HIMG_BIT_BUFFERED_WRITE_FAULT = 8;
    localparam int HIMG_BIT_STREAM_RECEIVE_DMA_IRQ = 7;
    localparam int HIMG_BIT_STREAM_TRANSMIT_DMA_IRQ = 6;
    localparam int HIMG_BIT_REPLY_PACKET_STORED = 5;
    localparam int HIMG_BIT_REQUEST_PACKET_STORED = 4;
    localparam int HIMG_BIT_ASYNC_REPLY_RX_DMA = 3;
    localparam int HIMG_BIT_ASYNC_REQUEST_RX_DMA = 2;
    localparam int HIMG_BIT_REPLY_SEND_DONE = 1;
    localparam int HIMG_BIT_REQUEST_SEND_DONE = 0;

    // writable mask positions; unused_bits 29..27, 18, 15..10 are zero here
    localparam logic [31:0] HIMG_WRITABLE = 32'hc7fb_03ff;
    // sources that can raise the line: all writable bits except the gate
    localparam logic [31:0] HIMG_SOURCES = 32'h47fb_03ff;
    localparam logic [31:0] HIMG_MASK_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // ahb constants
    // ------------------------------------------------------------
    localparam logic [1:0] HIMG_HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] HIMG_HTRANS_SEQ = 2'b11;
    localparam logic [2:0] HIMG_HSIZE_WORD = 3'b010;

    // bus transfer kind captured in the address phase
    typedef enum logic [1:0] {
        HIMG_OP_NONE = 2'b00,
        HIMG_OP_READ = 2'b01,
        HIMG_OP_SET = 2'b10,
        HIMG_OP_CLEAR = 2'b11
    } himg_op_t;

    // ahb request carrier
    typedef struct packed {
        logic hsel;
        logic [7:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
    } himg_ahb_req_t;

endpackage

/* logic/himg_gate.sv */
// combine per-source enables with event bits into one interrupt request
// assumes event bits arrive as synchronous levels from the event register
`timescale 1ns/1ps
module himg_gate (
    input wire logic [31:0] mask,
    input wire logic [31:0] events,
    output logic [31:0] pending,
    output logic irq_raw
);
    import himg_pkg::*;

    // per-source and, then or over sources, then the global gate
    always_comb begin
        pending = mask & events & HIMG_SOURCES;
        irq_raw = mask[HIMG_BIT_GLOBAL_IRQ_GATE] & (|pending);
    end

endmodule

/* logic/himg_top.sv */
// interrupt mask gate: set/clear mask register on ahb-lite and interrupt line
// assumes one 20 mhz clock, async active-low reset, ahb master with single words
// Function
// - reads at set and clear addresses both return the one mask register
// - with global gate set, irq follows enabled sources
// - with global gate clear, irq stays low whatever else holds
// - maker extra source raises irq only when mask 30 and event 30 set
// - link register arrived source needs mask 26 and event 26
// - overlong cycle source needs mask 25 and event 25
// - fatal fault source needs mask 24 and event 24
// - cycle timer mismatch source needs mask 23 and event 23
// - missed cycle needs bit 22 pair, seconds rollover bit 21 pair
// - new cycle began source needs mask 20 and event 20
// - link status transfer source needs mask 19 and event 19
// - bus reinit needs bit 17 pair, identity stream done bit 16 pair
// - lock reply failed bit 9 pair, buffered write fault bit 8 pair
// - stream receive dma bit 7 pair, stream transmit dma bit 6 pair
// - reply packet stored bit 5 pair, request packet stored bit 4 pair
// - async reply rx dma bit 3 pair, async request rx dma bit 2 pair
// - reply send done bit 1 pair, request send done bit 0 pair
// - unused bits 29..27, 18, 15..10 ignore writes and read zero
`timescale 1ns/1ps
module himg_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [31:0] event_bits,
    output logic irq_out,
    output logic [31:0] mask_out
);
    import himg_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        himg_op_t op;
        logic [7:0] addr;
        logic [31:0] mask;
        logic [31:0] rdata;
        logic irq;
    } himg_state_t;

    himg_state_t state_reg;
    himg_state_t state_next;
    himg_ahb_req_t req;
    logic [31:0] pending;
    logic irq_raw;
    logic [31:0] mask_after;

    // decoding of an address-phase address, used by the read path and the mask read check
    function automatic logic is_mask_addr(input logic [7:0] a);
        is_mask_addr = (a == HIMG_OFF_ENABLE_SET) || (a == HIMG_OFF_ENABLE_CLEAR);
    endfunction

    // one source pair behind the global gate, shared by the per-source checks
    function automatic logic pair_on(input logic [31:0] m, input logic [31:0] e, input int b);
        pair_on = m[HIMG_BIT_GLOBAL_IRQ_GATE] && m[b] && e[b];
    endfunction

    // ------------------------------------------------------------
    // bus request bundle
    // ------------------------------------------------------------
    always_comb begin
        req.hsel = hsel;
        req.haddr = haddr;
        req.htrans = htrans;
        req.hwrite = hwrite;
        req.hsize = hsize;
        req.hready = hready;
    end

    // gate of enabled sources against events
    himg_gate u_gate (
        .mask(state_reg.mask),
        .events(event_bits),
        .pending(pending),
        .irq_raw(irq_raw)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        mask_after = state_reg.mask;
        // data phase: apply write to the mask
        unique case (state_reg.op)
            HIMG_OP_SET: begin
                mask_after = state_reg.mask | (hwdata & HIMG_WRITABLE);
            end
            HIMG_OP_CLEAR: begin
                mask_after = state_reg.mask & ~(hwdata & HIMG_WRITABLE);
            end
            HIMG_OP_READ, HIMG_OP_NONE: begin
                mask_after = state_reg.mask;
            end
        endcase
        state_next.mask = mask_after & HIMG_WRITABLE;
        // address phase: capture a valid transfer
        state_next.op = HIMG_OP_NONE;
        state_next.addr = req.haddr;
        if (req.hsel && req.hready && (req.htrans == HIMG_HTRANS_NONSEQ || req.htrans == HIMG_HTRANS_SEQ)) begin
            if (!req.hwrite) begin
                state_next.op = HIMG_OP_READ;
            end else if (req.haddr == HIMG_OFF_ENABLE_SET) begin
                state_next.op = HIMG_OP_SET;
            end else if (req.haddr == HIMG_OFF_ENABLE_CLEAR) begin
                state_next.op = HIMG_OP_CLEAR;
            end
        end
        // read data prepared for the following data phase
        state_next.rdata = 32'h0000_0000;
        if (state_next.op == HIMG_OP_READ) begin
            if (is_mask_addr(req.haddr)) begin
                state_next.rdata = mask_after & HIMG_WRITABLE;
            end else if (req.haddr == HIMG_OFF_EVENT_VIEW) begin
                state_next.rdata = pending;
            end
        end
        // registered interrupt line
        state_next.irq = irq_raw;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg.op <= HIMG_OP_NONE;
            state_reg.addr <= 8'h00;
            state_reg.mask <= HIMG_MASK_RESET;
            state_reg.rdata <= 32'h0000_0000;
            state_reg.irq <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs: zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = state_reg.rdata;
    assign irq_out = state_reg.irq;
    assign mask_out = state_reg.mask;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // helper: write data of the last data phase, declared before the checks use it
    logic [31:0] hwdata_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hwdata_q <= 32'h0000_0000;
        end else begin
            hwdata_q <= hwdata;
        end
    end

    property p_read_mask;
        @(posedge hclk) disable iff (!hresetn)
        (hsel && hready && htrans == HIMG_HTRANS_NONSEQ && !hwrite && is_mask_addr(haddr)
            && state_reg.op == HIMG_OP_NONE)
            |=> (hrdata == state_reg.mask);
    endproperty
    a_read_mask: assert property (p_read_mask) else $error("mask read mismatch");

    property p_gate_on;
        @(posedge hclk) disable iff (!hresetn)
        (state_reg.mask[HIMG_BIT_GLOBAL_IRQ_GATE] && |(state_reg.mask & event_bits & HIMG_SOURCES))
            |=> irq_out;
    endproperty
    a_gate_on: assert property (p_gate_on) else $error("irq missing with gate on");

    property p_gate_off;
        @(posedge hclk) disable iff (!hresetn)
        !state_reg.mask[HIMG_BIT_GLOBAL_IRQ_GATE] |=> !irq_out;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("irq with gate off");

    property p_maker_source;
        @(posedge hclk) disable iff (!hresetn)
        (state_reg.mask == 32'hc000_0000 && event_bits == 32'h4000_0000) |=> irq_out;
    endproperty
    a_maker_source: assert property (p_maker_source) else $error("maker source ignored");

    property p_pair_needed;
        @(posedge hclk) disable iff (!hresetn)
        ((state_reg.mask & event_bits & HIMG_SOURCES) == 32'h0000_0000) |=> !irq_out;
    endproperty
    a_pair_needed: assert property (p_pair_needed) else $error("irq without a pair");

    property p_reserved_zero;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |-> ((mask_out & ~HIMG_WRITABLE) == 32'h0000_0000);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved mask bit set");

    property p_set_write;
        @(posedge hclk) disable iff (!hresetn)
        (state_reg.op == HIMG_OP_SET) |=> ((mask_out & (hwdata_q & HIMG_WRITABLE)) == (hwdata_q & HIMG_WRITABLE));
    endproperty
    a_set_write: assert property (p_set_write) else $error("set write lost");

    property p_clear_write;
        @(posedge hclk) disable iff (!hresetn)
        (state_reg.op == HIMG_OP_CLEAR) |=> ((mask_out & hwdata_q) == 32'h0000_0000);
    endproperty
    a_clear_write: assert property (p_clear_write) else $error("clear write lost");

    property p_idle_hold;
        @(posedge hclk) disable iff (!hresetn)
        (state_reg.op == HIMG_OP_NONE || state_reg.op == HIMG_OP_READ) |=> $stable(mask_out);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("mask changed without write");

    property p_set_addr;
        @(posedge hclk) disable iff (!hresetn)
        (state_reg.op == HIMG_OP_SET) |-> (state_reg.addr == HIMG_OFF_ENABLE_SET);
    endproperty
    a_set_addr: assert property (p_set_addr) else $error("set applied off its address");

    property p_clear_addr;
        @(posedge hclk) disable iff (!hresetn)
        (state_reg.op == HIMG_OP_CLEAR) |-> (state_reg.addr == HIMG_OFF_ENABLE_CLEAR);
    endproperty
    a_clear_addr: assert property (p_clear_addr) else $error("clear applied off its address");

    property p_write_keep;
        @(posedge hclk) disable iff (!hresetn)
        (state_reg.op == HIMG_OP_SET || state_reg.op == HIMG_OP_CLEAR)
            |=> ((mask_out & ~hwdata_q) == ($past(mask_out) & ~hwdata_q));
    endproperty
    a_write_keep: assert property (p_write_keep) else $error("bit written with zero changed");

    property p_rdata_idle;
        @(posedge hclk) disable iff (!hresetn)
        !(hsel && hready && !hwrite && (htrans == HIMG_HTRANS_NONSEQ || htrans == HIMG_HTRANS_SEQ))
            |=> (hrdata == 32'h0000_0000);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside a read");

    property p_event_view;
        @(posedge hclk) disable iff (!hresetn)
        (hsel && hready && htrans == HIMG_HTRANS_NONSEQ && !hwrite && haddr == HIMG_OFF_EVENT_VIEW)
            |=> (hrdata == ($past(mask_out) & $past(event_bits) & HIMG_SOURCES));
    endproperty
    a_event_view: assert property (p_event_view) else $error("pending view mismatch");

    // ------------------------------------------------------------
    // per-source pairs behind the global gate
    // ------------------------------------------------------------
    property p_link_reg_pair;
        @(posedge hclk) disable iff (!hresetn)
        pair_on(mask_out, event_bits, HIMG_BIT_LINK_REG_VALUE_ARRIVED) |=> irq_out;
    endproperty
    a_link_reg_pair: assert property (p_link_reg_pair) else $error("link register source ignored");

    property p_overlong_pair;
        @(posedge hclk) disable iff (!hresetn)
        pair_on(mask_out, event_bits, HIMG_BIT_OVERLONG_CYCLE) |=> irq_out;
    endproperty
    a_overlong_pair: assert property (p_overlong_pair) else $error("overlong cycle source ignored");

    property p_fatal_pair;
        @(posedge hclk) disable iff (!hresetn)
        pair_on(mask_out, event_bits, HIMG_BIT_FATAL_FAULT) |=> irq_out;
    endproperty
    a_fatal_pair: assert property (p_fatal_pair) else $error("fatal fault source ignored");

    property p_mismatch_pair;
        @(posedge hclk) disable iff (!hresetn)
        pair_on(mask_out, event_bits, HIMG_BIT_CYCLE_TIMER_MISMATCH) |=> irq_out;
    endproperty
    a_mismatch_pair: assert property (p_mismatch_pair) else $error("timer mismatch source ignored");

    property p_cycle_loss_pairs;
        @(posedge hclk) disable iff (!hresetn)
        (pair_on(mask_out, event_bits, HIMG_BIT_MISSED_CYCLE_START)
            || pair_on(mask_out, event_bits, HIMG_BIT_TIMER_SECONDS_ROLLOVER)) |=> irq_out;
    endproperty
    a_cycle_loss_pairs: assert property (p_cycle_loss_pairs) else $error("cycle timing source ignored");

    property p_new_cycle_pair;
        @(posedge hclk) disable iff (!hresetn)
        pair_on(mask_out, event_bits, HIMG_BIT_NEW_CYCLE_BEGAN) |=> irq_out;
    endproperty
    a_new_cycle_pair: assert property (p_new_cycle_pair) else $error("new cycle source ignored");

    property p_link_status_pair;
        @(posedge hclk) disable iff (!hresetn)
        pair_on(mask_out, event_bits, HIMG_BIT_LINK_STATUS_XFER) |=> irq_out;
    endproperty
    a_link_status_pair: assert property (p_link_status_pair) else $error("link status source ignored");

    property p_bus_init_pairs;
        @(posedge hclk) disable iff (!hresetn)
        (pair_on(mask_out, event_bits, HIMG_BIT_SERIAL_BUS_REINIT)
            || pair_on(mask_out, event_bits, HIMG_BIT_IDENTITY_STREAM_DONE)) |=> irq_out;
    endproperty
    a_bus_init_pairs: assert property (p_bus_init_pairs) else $error("bus init source ignored");

    property p_fault_pairs;
        @(posedge hclk) disable iff (!hresetn)
        (pair_on(mask_out, event_bits, HIMG_BIT_LOCK_REPLY_FAILED)
            || pair_on(mask_out, event_bits, HIMG_BIT_BUFFERED_WRITE_FAULT)) |=> irq_out;
    endproperty
    a_fault_pairs: assert property (p_fault_pairs) else $error("reply or write fault source ignored");

    property p_stream_dma_pairs;
        @(posedge hclk) disable iff (!hresetn)
        (pair_on(mask_out, event_bits, HIMG_BIT_STREAM_RECEIVE_DMA_IRQ)
            || pair_on(mask_out, event_bits, HIMG_BIT_STREAM_TRANSMIT_DMA_IRQ)) |=> irq_out;
    endproperty
    a_stream_dma_pairs: assert property (p_stream_dma_pairs) else $error("stream dma source ignored");

    property p_packet_pairs;
        @(posedge hclk) disable iff (!hresetn)
        (pair_on(mask_out, event_bits, HIMG_BIT_REPLY_PACKET_STORED)
            || pair_on(mask_out, event_bits, HIMG_BIT_REQUEST_PACKET_STORED)) |=> irq_out;
    endproperty
    a_packet_pairs: assert property (p_packet_pairs) else $error("packet stored source ignored");

    property p_async_rx_pairs;
        @(posedge hclk) disable iff (!hresetn)
        (pair_on(mask_out, event_bits, HIMG_BIT_ASYNC_REPLY_RX_DMA)
            || pair_on(mask_out, event_bits, HIMG_BIT_ASYNC_REQUEST_RX_DMA)) |=> irq_out;
    endproperty
    a_async_rx_pairs: assert property (p_async_rx_pairs) else $error("async receive source ignored");

    property p_send_done_pairs;
        @(posedge hclk) disable iff (!hresetn)
        (pair_on(mask_out, event_bits, HIMG_BIT_REPLY_SEND_DONE)
            || pair_on(mask_out, event_bits, HIMG_BIT_REQUEST_SEND_DONE)) |=> irq_out;
    endproperty
    a_send_done_pairs: assert property (p_send_done_pairs) else $error("send done source ignored");

endmodule

/* verification/tb_host_interrupt_mask_gate.sv */
// testbench of the interrupt mask gate: ahb-lite master tasks and scenarios
// assumes himg_top answers with hreadyout fed back as hready, one 50 ns clock
`timescale 1ns/1ps
module tb_host_interrupt_mask_gate;
    import himg_pkg::*;

    // ------------------------------------------------------------
    // signals and design
    // ------------------------------------------------------------
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq_out;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, event_bits, mask_out, rd;
    int mismatches, tests_run;

    himg_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .event_bits(event_bits), .irq_out(irq_out),
        .mask_out(mask_out));

    // free-running 20 mhz clock
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task summarize;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // bounded wait for hready sampled high at a rising edge
    task wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            mismatches++;
            $display("[FAIL] %0t bus wait ran out", $time);
            summarize();
        end
    endtask

    // one single-word transfer; read data lands in rd
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HIMG_HTRANS_NONSEQ;
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask

    // irq is registered: give it two edges, look at the falling edge
    task expect_irq(input logic e);
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        check({31'h0, irq_out}, {31'h0, e});
        @(posedge hclk);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_reset;
        check(mask_out, 32'h0);
        check({31'h0, irq_out}, 32'h0);
        bus(1'b0, 8'h88, 32'h0);
        check(rd, 32'h0);
    endtask

    // set, clear, reserved bits and an unmapped place
    task t_setclr;
        bus(1'b1, 8'h88, 32'hffff_ffff);
        bus(1'b0, 8'h88, 32'h0);
        check(rd, 32'hc7fb_03ff);
        bus(1'b0, 8'h8c, 32'h0);
        check(rd, 32'hc7fb_03ff);
        bus(1'b1, 8'h8c, 32'h0000_00f0);
        bus(1'b0, 8'h8c, 32'h0);
        check(rd, 32'hc7fb_030f);
        bus(1'b1, 8'h40, 32'h0);
        bus(1'b0, 8'h40, 32'h0);
        check(rd, 32'h0);
        bus(1'b0, 8'h88, 32'h0);
        check(rd, 32'hc7fb_030f);
    endtask

    // each source alone: its own event raises, all others do not
    task t_sources;
        for (int b = 0; b < 31; b++) begin
            if (32'h47fb_03ff & (32'h1 << b)) begin
                bus(1'b1, 8'h8c, 32'hffff_ffff);
                bus(1'b1, 8'h88, 32'h8000_0000 | (32'h1 << b));
                event_bits <= 32'h1 << b;
                expect_irq(1'b1);
                event_bits <= ~(32'h1 << b);
                expect_irq(1'b0);
            end
        end
    endtask

    // master enable off, then on, then reserved events, then a mid-run reset
    task t_gate;
        bus(1'b1, 8'h88, 32'hffff_ffff);
        bus(1'b1, 8'h8c, 32'h8000_0000);
        event_bits <= 32'hffff_ffff;
        expect_irq(1'b0);
        bus(1'b0, 8'h90, 32'h0);
        check(rd, 32'h47fb_03ff);
        bus(1'b1, 8'h88, 32'h8000_0000);
        expect_irq(1'b1);
        event_bits <= 32'h3804_fc00;
        expect_irq(1'b0);
        event_bits <= 32'h0000_0001;
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        check(mask_out, 32'h0);
        check({31'h0, irq_out}, 32'h0);
        @(posedge hclk);
        // traffic right after the mid-run release
        bus(1'b1, 8'h88, 32'h0000_0001);
        bus(1'b0, 8'h8c, 32'h0);
        check(rd, 32'h0000_0001);
        expect_irq(1'b0);
        bus(1'b1, 8'h88, 32'h8000_0000);
        expect_irq(1'b1);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        mismatches = 0;
        tests_run = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = HIMG_HSIZE_WORD;
        hwdata = 32'h0;
        event_bits = 32'h0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_setclr();
        t_sources();
        t_gate();
        summarize();
    end
endmodule
